/* logic/ccf_pkg.sv */
// package for the channel configuration field block
// assumes a 16-channel sequencer and a plain strobe register port
package ccf_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int unsigned CCF_NUM_CH        = 16;
  localparam logic [7:0]  CCF_CH_BASE_OFF   = 8'h09;  // channel_config 0..15 at 0x09..0x18
  localparam logic [7:0]  CCF_STATUS_OFF    = 8'h20;
  localparam logic [7:0]  CCF_IRQ_CLR_OFF   = 8'h21;
  localparam logic [7:0]  CCF_IRQ_EN_OFF    = 8'h22;
  localparam logic [7:0]  CCF_MISC_OFF      = 8'h23;
  localparam logic [7:0]  CCF_LIMITS_OFF    = 8'h24;
  // ---------------------------------------------------------------
  // field layout of channel_config
  // ---------------------------------------------------------------
  localparam int unsigned CCF_CH_W          = 24;
  localparam int unsigned CCF_SETUP_LSB     = 20;
  localparam int unsigned CCF_SWITCH_BIT    = 19;
  localparam int unsigned CCF_THR_BIT       = 18;
  localparam int unsigned CCF_POS_SEL_LSB   = 13;
  localparam logic [23:0] CCF_CH0_RESET     = 24'h800100;
  localparam logic [23:0] CCF_CHN_RESET     = 24'h000100;
  localparam int unsigned CCF_MISC_PERMIT   = 0;
  // ---------------------------------------------------------------
  // positive input codes
  // ---------------------------------------------------------------
  localparam logic [4:0]  CCF_POS_LAST_PIN  = 5'h0d;
  localparam logic [4:0]  CCF_POS_AVDD_M    = 5'h15;
  localparam logic [4:0]  CCF_POS_IOVDD_M   = 5'h17;
  localparam logic [4:0]  CCF_POS_DREG_M    = 5'h1b;
  // interrupt status layout
  localparam int unsigned CCF_ST_LOW        = 0;
  localparam int unsigned CCF_ST_HIGH       = 1;
  localparam int unsigned CCF_ST_W          = 2;
endpackage : ccf_pkg

/* logic/ccf_input_route.sv */
// decoder for the positive input selector code
// assumes the caller supplies the active-channel condition on active_in, which gates every output
`timescale 1ns/1ps
module ccf_input_route
  import ccf_pkg::*;
(
  input  wire logic [4:0]  code_in,
  input  wire logic        active_in,
  output logic      [13:0] pin_sel_out,
  output logic      [2:0]  supply_tap_out
);
  // ---------------------------------------------------------------
  // one-hot routing, unused codes route nothing
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g <= int'(CCF_POS_LAST_PIN); g++) begin : g_pin
      assign pin_sel_out[g] = active_in && (code_in == 5'(g));
    end
  endgenerate
  assign supply_tap_out[0] = active_in && (code_in == CCF_POS_AVDD_M);
  assign supply_tap_out[1] = active_in && (code_in == CCF_POS_IOVDD_M);
  assign supply_tap_out[2] = active_in && (code_in == CCF_POS_DREG_M);
endmodule : ccf_input_route

/* logic/ccf_channel_config.sv */
// per-channel configuration fields: setup select, power switch, threshold monitor, positive input
// assumes the sequencer reports the channel it converts and a result strobe, all on core_clk_in
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module ccf_channel_config
  import ccf_pkg::*;
#(
  parameter int unsigned NUM_CH = CCF_NUM_CH,
  parameter int unsigned DATA_W = 24
) (
  input  wire logic              core_clk_in,
  input  wire logic              reset_n_in,
  input  wire logic [7:0]        reg_addr_in,
  input  wire logic [23:0]       reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic      [23:0]       reg_rdata_out,
  input  wire logic              seq_busy_in,
  input  wire logic [3:0]        seq_channel_in,
  input  wire logic              result_valid_in,
  input  wire logic [DATA_W-1:0] result_data_in,
  input  wire logic              power_down_in,
  input  wire logic              standby_in,
  input  wire logic              fifo_enable_in,
  output logic      [2:0]        setup_select_out,
  output logic                   power_switch_pin_out,
  output logic      [13:0]       analog_input_pin_sel_out,
  output logic      [2:0]        supply_tap_sel_out,
  output logic                   limit_low_out,
  output logic                   limit_high_out,
  output logic                   irq_out
);
  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  // reset falls at once but rises only after two clean edges
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // function: field pickers
  // ---------------------------------------------------------------
  function automatic logic [2:0] ccf_setup_of(input logic [23:0] r);
    ccf_setup_of = r[CCF_SETUP_LSB +: 3];
  endfunction : ccf_setup_of

  function automatic logic [4:0] ccf_pos_sel_of(input logic [23:0] r);
    ccf_pos_sel_of = r[CCF_POS_SEL_LSB +: 5];
  endfunction : ccf_pos_sel_of

  // every single-register offset goes through this one compare; the channel range is decoded apart
  function automatic logic ccf_addr_is(input logic [7:0] a, input logic [7:0] off);
    ccf_addr_is = (a == off);
  endfunction : ccf_addr_is

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  logic [23:0]         ch_q [NUM_CH];
  logic [CCF_ST_W-1:0] status_q;
  logic [CCF_ST_W-1:0] irq_en_q;
  logic                permit_q;
  logic [DATA_W-1:0]   low_limit_value_q;
  logic [DATA_W-1:0]   high_limit_value_q;

  wire logic [7:0] ch_idx   = reg_addr_in - CCF_CH_BASE_OFF;
  wire logic       ch_hit   = (reg_addr_in >= CCF_CH_BASE_OFF) &&
                              (ch_idx < 8'(NUM_CH));
  wire logic       st_hit   = ccf_addr_is(reg_addr_in, CCF_STATUS_OFF);
  wire logic       clr_hit  = ccf_addr_is(reg_addr_in, CCF_IRQ_CLR_OFF);
  wire logic       en_hit   = ccf_addr_is(reg_addr_in, CCF_IRQ_EN_OFF);
  wire logic       misc_hit = ccf_addr_is(reg_addr_in, CCF_MISC_OFF);
  wire logic       low_hit  = ccf_addr_is(reg_addr_in, CCF_LIMITS_OFF);
  wire logic       high_hit = ccf_addr_is(reg_addr_in, CCF_LIMITS_OFF + 8'h01);

  // ---------------------------------------------------------------
  // write strobes
  // ---------------------------------------------------------------
  wire logic       wr_ch    = reg_wr_in && ch_hit;
  wire logic       wr_clr   = reg_wr_in && clr_hit;
  wire logic       wr_en    = reg_wr_in && en_hit;
  wire logic       wr_misc  = reg_wr_in && misc_hit;
  wire logic       wr_low   = reg_wr_in && low_hit;
  wire logic       wr_high  = reg_wr_in && high_hit;

  // ---------------------------------------------------------------
  // channel registers
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      always_ff @(posedge core_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
          ch_q[g] <= (g == 0) ? CCF_CH0_RESET : CCF_CHN_RESET;
        end else if (wr_ch && (ch_idx[3:0] == 4'(g))) begin
          ch_q[g] <= reg_wdata_in;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // one short process per register keeps each write path on its own
  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_en_q <= '0;
    end else if (wr_en) begin
      irq_en_q <= reg_wdata_in[CCF_ST_W-1:0];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      permit_q <= 1'b0;
    end else if (wr_misc) begin
      permit_q <= reg_wdata_in[CCF_MISC_PERMIT];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      low_limit_value_q <= '0;
    end else if (wr_low) begin
      low_limit_value_q <= reg_wdata_in[DATA_W-1:0];
    end
  end

  // an all-ones high limit keeps the above flag quiet until software sets it
  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      high_limit_value_q <= '1;
    end else if (wr_high) begin
      high_limit_value_q <= reg_wdata_in[DATA_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // active channel fields
  // ---------------------------------------------------------------
  wire logic [23:0] act_reg       = ch_q[seq_channel_in];
  wire logic        active        = seq_busy_in;
  wire logic [2:0]  setup_d       = ccf_setup_of(act_reg);
  wire logic        act_switch_en = act_reg[CCF_SWITCH_BIT];
  wire logic [4:0]  act_pos_sel   = ccf_pos_sel_of(act_reg);
  // standby without permit and power-down both force the switch open
  wire logic        switch_blocked = power_down_in ||
                                     (standby_in && !permit_q);
  wire logic        switch_d       = active && act_switch_en &&
                                     !switch_blocked;

  // ---------------------------------------------------------------
  // positive input routing
  // ---------------------------------------------------------------
  logic [13:0] pin_sel_d;
  logic [2:0]  tap_d;
  ccf_input_route u_route (
    .code_in        (act_pos_sel),
    .active_in      (active),
    .pin_sel_out    (pin_sel_d),
    .supply_tap_out (tap_d)
  );

  // ---------------------------------------------------------------
  // threshold monitor
  // ---------------------------------------------------------------
  wire logic res_ch_thr = ch_q[seq_channel_in][CCF_THR_BIT];
  wire logic monitor    = result_valid_in && res_ch_thr &&
                          fifo_enable_in;
  wire logic below      = monitor && (result_data_in < low_limit_value_q);
  wire logic above      = monitor && (result_data_in > high_limit_value_q);
  wire logic [CCF_ST_W-1:0] events = {above, below};
  wire logic [CCF_ST_W-1:0] clr    = wr_clr ? reg_wdata_in[CCF_ST_W-1:0] : '0;
  // set beats clear so an event in the clear cycle survives
  wire logic [CCF_ST_W-1:0] status_d = (status_q & ~clr) | events;

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  // the clear offset has no source here, so it reads back as zero
  wire logic [23:0] ch_word   = ch_q[ch_idx[3:0]];
  wire logic [23:0] st_word   = 24'(status_q);
  wire logic [23:0] en_word   = 24'(irq_en_q);
  wire logic [23:0] misc_word = 24'(permit_q);
  wire logic [23:0] low_word  = 24'(low_limit_value_q);
  wire logic [23:0] high_word = 24'(high_limit_value_q);

  logic [23:0] rdata_d;
  always_comb begin
    rdata_d = 24'h000000;
    if (ch_hit) begin
      rdata_d = ch_word;
    end else if (st_hit) begin
      rdata_d = st_word;
    end else if (en_hit) begin
      rdata_d = en_word;
    end else if (misc_hit) begin
      rdata_d = misc_word;
    end else if (low_hit) begin
      rdata_d = low_word;
    end else if (high_hit) begin
      rdata_d = high_word;
    end
  end

  // data stand only in the cycle after the strobe, zero otherwise
  wire logic [23:0] rd_word_d = reg_rd_in ? rdata_d : 24'h000000;

  // ---------------------------------------------------------------
  // read data and status flops
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reg_rdata_out <= 24'h000000;
    end else begin
      reg_rdata_out <= rd_word_d;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  // ---------------------------------------------------------------
  // channel output flops
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      setup_select_out <= 3'h0;
    end else begin
      setup_select_out <= setup_d;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      power_switch_pin_out <= 1'b0;
    end else begin
      power_switch_pin_out <= switch_d;
    end
  end

  // pins and taps share one flop group so a code change never shows two routes
  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      analog_input_pin_sel_out <= 14'h0000;
      supply_tap_sel_out       <= 3'h0;
    end else begin
      analog_input_pin_sel_out <= pin_sel_d;
      supply_tap_sel_out       <= tap_d;
    end
  end

  // ---------------------------------------------------------------
  // monitor output flops
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      limit_low_out <= 1'b0;
    end else begin
      limit_low_out <= below;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      limit_high_out <= 1'b0;
    end else begin
      limit_high_out <= above;
    end
  end

  // level interrupt from the next status, so it rises with the status bit
  wire logic irq_d = |(status_d & irq_en_q);
  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= irq_d;
    end
  end
endmodule : ccf_channel_config

/* verif/ccf_asserts.sv */
// port checker for ccf_channel_config
// assumes a bind onto the top module, one clock domain
`timescale 1ns/1ps
module ccf_asserts (
  input wire logic        core_clk_in,
  input wire logic        reset_n_in,
  input wire logic        reg_rd_in,
  input wire logic [23:0] reg_rdata_out,
  input wire logic        seq_busy_in,
  input wire logic        result_valid_in,
  input wire logic        power_down_in,
  input wire logic        fifo_enable_in,
  input wire logic        power_switch_pin_out,
  input wire logic [13:0] analog_input_pin_sel_out,
  input wire logic [2:0]  supply_tap_sel_out,
  input wire logic        limit_low_out,
  input wire logic        limit_high_out,
  input wire logic        irq_out
);
  // ------
  // rules
  // ------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  a_pd_opens_sw: assert property (power_down_in |=> !power_switch_pin_out)
    else $error("switch closed in power-down");
  a_idle_sw_open: assert property (!seq_busy_in |=> !power_switch_pin_out)
    else $error("switch closed while idle");
  a_idle_no_route: assert property (!seq_busy_in |=> !(|analog_input_pin_sel_out) && !(|supply_tap_sel_out))
    else $error("input routed while idle");
  a_pin_one_hot: assert property (
    |analog_input_pin_sel_out |-> $onehot(analog_input_pin_sel_out) && !(|supply_tap_sel_out))
    else $error("pin select not one-hot");
  a_tap_one_hot: assert property ($onehot0(supply_tap_sel_out))
    else $error("two supply taps");
  a_fifo_off_quiet: assert property (
    !fifo_enable_in && result_valid_in |=> !limit_low_out && !limit_high_out)
    else $error("limit flag with fifo off");
  a_limit_has_cause: assert property (
    limit_low_out || limit_high_out |-> $past(result_valid_in && fifo_enable_in))
    else $error("limit flag without result");
  a_rdata_idle_zero: assert property (!reg_rd_in |=> reg_rdata_out == 24'h0)
    else $error("read data outside read");
  c_switch: cover property (power_switch_pin_out);
  c_low: cover property (limit_low_out);
  c_irq: cover property (irq_out);
endmodule : ccf_asserts

/* verif/channel_config_fields_test.sv */
// bench for ccf_channel_config, model of channel words in an int array
// assumes ccf_pkg compiled first; checker bound at the foot
`timescale 1ns/1ps
module channel_config_fields_test;
  import ccf_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, busy = 1'b0, rv = 1'b0;
  logic        pd = 1'b0, sb = 1'b0, fe = 1'b0, sw, lo, hi, irq;
  logic [7:0]  addr = 8'h00;
  logic [23:0] wd = 24'h0, res = 24'h0, rdata;
  logic [3:0]  chn = 4'h0;
  logic [2:0]  setup, tap;
  logic [13:0] pin;
  logic [31:0] lf = 32'd99550, v;
  int          failures = 0, num_checks = 0, cyc = 0;
  int          ch_m [16];
  ccf_channel_config u_ccf_channel_config (.core_clk_in(clk), .reset_n_in(rst_n), .reg_addr_in(addr),
    .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .seq_busy_in(busy),
    .seq_channel_in(chn), .result_valid_in(rv), .result_data_in(res), .power_down_in(pd),
    .standby_in(sb), .fifo_enable_in(fe), .setup_select_out(setup), .power_switch_pin_out(sw),
    .analog_input_pin_sel_out(pin), .supply_tap_sel_out(tap), .limit_low_out(lo),
    .limit_high_out(hi), .irq_out(irq));
  // ------
  // tasks
  // ------
  function automatic logic [31:0] lfsr();
    lf = lf[0] ? (lf >> 1) ^ 32'h80200003 : lf >> 1;
    return lf;
  endfunction : lfsr
  task automatic check(string nm, logic [23:0] seen, logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wrreg(logic [7:0] a, logic [23:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrreg
  task automatic wrch(int c, logic [23:0] d);
    ch_m[c] = d;
    wrreg(CCF_CH_BASE_OFF + 8'(c), d);
  endtask : wrch
  task automatic rdreg(logic [7:0] a, logic [23:0] exp, string nm);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(nm, rdata, exp);
  endtask : rdreg
  // outputs lag the inputs by one edge
  task automatic conv(logic b, int c);
    @(posedge clk);
    busy <= b;
    chn <= 4'(c);
    @(posedge clk);
    #1;
  endtask : conv
  task automatic pulse(logic [23:0] d);
    @(posedge clk);
    res <= d;
    rv <= 1'b1;
    @(posedge clk);
    rv <= 1'b0;
    #1;
  endtask : pulse
  task automatic report_and_stop();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      report_and_stop();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rdreg(8'h09, 24'h800100, "ch0 reset");
    rdreg(8'h0e, 24'h000100, "ch5 reset");
    rdreg(8'h30, 24'h0, "unmapped");
    for (int c = 0; c < 16; c++) begin
      v = lfsr();
      v[22:20] = 3'(c);
      wrch(c, v[23:0]);
    end
    for (int c = 0; c < 16; c++) begin
      rdreg(CCF_CH_BASE_OFF + 8'(c), 24'(ch_m[c]), "chan rw");
      conv(1'b0, c);
      check("setup", {21'h0, setup}, 24'((ch_m[c] >> 20) & 7));
    end
    wrch(1, 24'h080000);
    for (int k = 0; k < 8; k++) begin
      wrreg(CCF_MISC_OFF, {23'h0, k[2]});
      pd <= k[0];
      sb <= k[1];
      conv(1'b1, 1);
      check("switch", {23'h0, sw}, {23'h0, !k[0] && !(k[1] && !k[2])});
    end
    wrch(0, 24'h0);
    pd <= 1'b0;
    sb <= 1'b0;
    conv(1'b1, 0);
    check("other chan", {23'h0, sw}, 24'h0);
    conv(1'b0, 1);
    check("idle switch", {23'h0, sw}, 24'h0);
    wrch(1, 24'h0);
    conv(1'b1, 1);
    check("switch off", {23'h0, sw}, 24'h0);
    for (int k = 0; k < 32; k++) begin
      wrch(3, 24'(k << 13));
      conv(1'b1, 3);
      check("pin", 24'(pin), (k < 14) ? 24'h1 << k : 24'h0);
      check("tap", 24'(tap), {21'h0, k == 27, k == 23, k == 21});
    end
    conv(1'b0, 3);
    check("idle pin", 24'(pin), 24'h0);
    wrreg(CCF_LIMITS_OFF, 24'h000100);
    wrreg(CCF_LIMITS_OFF + 8'h01, 24'h000800);
    wrreg(CCF_IRQ_EN_OFF, 24'h3);
    conv(1'b1, 2);
    for (int k = 0; k < 4; k++) begin
      wrch(2, {5'h0, k[1], 18'h0});
      fe <= k[0];
      pulse(24'h000050);
      check("low", {23'h0, lo}, {23'h0, k == 3});
      check("irq", {23'h0, irq}, {23'h0, k == 3});
      pulse(24'h000900);
      check("high", {23'h0, hi}, {23'h0, k == 3});
      rdreg(CCF_STATUS_OFF, (k == 3) ? 24'h3 : 24'h0, "status");
      wrreg(CCF_IRQ_CLR_OFF, 24'h3);
    end
    rdreg(CCF_IRQ_CLR_OFF, 24'h0, "clear reads 0");
    check("irq cleared", {23'h0, irq}, 24'h0);
    wrreg(CCF_IRQ_EN_OFF, 24'h2);
    pulse(24'h000050);
    check("irq masked", {23'h0, irq}, 24'h0);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rdreg(CCF_CH_BASE_OFF + 8'h02, CCF_CHN_RESET, "ch2 after reset");
    rdreg(CCF_CH_BASE_OFF + 8'h03, CCF_CHN_RESET, "ch3 after reset");
    report_and_stop();
  end
endmodule : channel_config_fields_test
bind ccf_channel_config ccf_asserts u_ccf_asserts (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .seq_busy_in(seq_busy_in),
  .result_valid_in(result_valid_in), .power_down_in(power_down_in), .fifo_enable_in(fifo_enable_in),
  .power_switch_pin_out(power_switch_pin_out), .analog_input_pin_sel_out(analog_input_pin_sel_out),
  .supply_tap_sel_out(supply_tap_sel_out), .limit_low_out(limit_low_out), .limit_high_out(limit_high_out),
  .irq_out(irq_out));
